// ==== hdl/cns_defines.svh ====
// Object indexes, field positions, limits and state codes of the node supervision block.
`ifndef CNS_DEFINES_SVH
`define CNS_DEFINES_SVH
`define CNS_IDX_CONS       16'h1016
`define CNS_IDX_PROD       16'h1017
`define CNS_IDX_RXCOM      16'h1400
`define CNS_IDX_TXCOM      16'h1800
`define CNS_IDX_RXMAP      16'h1600
`define CNS_IDX_TXMAP      16'h1A00
`define CNS_IDX_WSRC       16'h280D
`define CNS_IDX_WLIM       16'h280E
`define CNS_IDX_PAD        16'h2807
`define CNS_SUB_COUNT      8'h00
`define CNS_SUB_CONS       8'h01
`define CNS_SUB_TTYPE      8'h02
`define CNS_CONS_ENTRIES   32'h0000_0001
`define CNS_MAP_MAX_OBJ    4'h8
`define CNS_MAP_MAX_BITS   10'h040
`define CNS_TTYPE_RST      8'hFF
`define CNS_NODE_HI        23
`define CNS_NODE_LO        16
`define CNS_TIME_HI        15
`define CNS_TIME_LO        0
`define CNS_RSV_HI         31
`define CNS_RSV_LO         24
`define CNS_LEN_HI         7
`define CNS_LEN_LO         0
`define CNS_ST_BOOT        8'h00
`define CNS_ST_STOPPED     8'h04
`define CNS_ST_OPER        8'h05
`define CNS_ST_PREOP       8'h7F
`endif

// ==== hdl/cns_pkg.sv ====
// Types shared by the node supervision block and its users.
package cns_pkg;
  `include "cns_defines.svh"

  typedef enum logic [1:0] {
    CNS_NMT_INIT,
    CNS_NMT_PREOP,
    CNS_NMT_OPER,
    CNS_NMT_STOPPED
  } cns_nmt_e;

  typedef enum logic [1:0] {
    CNS_CONS_IDLE,
    CNS_CONS_RUN,
    CNS_CONS_LOST
  } cns_cons_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] wdata;
  } cns_od_req_s;

  typedef struct packed {
    logic        done;
    logic        abort;
    logic [31:0] rdata;
  } cns_od_rsp_s;

  typedef struct packed {
    logic [7:0][7:0][31:0] mapEntry;
    logic [7:0][3:0]       mapCount;
    logic [7:0][7:0]       transType;
    logic [15:0]           prodTime;
    logic [31:0]           consSet;
    logic                  watchSrc;
    logic [15:0]           watchLimit;
  } cns_comm_s;
endpackage

// ==== hdl/cns_node_supervision.sv ====
// Heartbeat producer and consumer, telegram watch and mapping checks of one node.
`timescale 1ns/1ps
`include "cns_defines.svh"
module cns_node_supervision (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              msTick,
  input  cns_pkg::cns_od_req_s   odReq,
  output cns_pkg::cns_od_rsp_s   odRsp,
  input  cns_pkg::cns_nmt_e      nmtState,
  input  wire logic              storeCmd,
  input  wire logic              restoreCmd,
  output logic                   datasetValid,
  output logic                   hbTxValid,
  input  wire logic              hbTxReady,
  output logic [7:0]             hbTxState,
  input  wire logic              hbRxValid,
  input  wire logic [7:0]        hbRxNode,
  input  wire logic [7:0]        hbRxState,
  output logic                   hbEvent,
  output logic                   consKnown,
  output logic [6:0]             consPeerState,
  input  wire logic              syncRx,
  input  wire logic              rxPdoRx,
  output logic                   tlgFailEvt,
  output logic                   tlgFailed,
  output logic                   errMsgValid,
  input  wire logic              errMsgReady,
  output logic [7:0]             pdoActive
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // True when the index falls in the block of four starting at base.
  function automatic logic inQuad(input logic [15:0] idx, input logic [15:0] base);
    inQuad = (idx[15:2] == base[15:2]);
  endfunction

  // Total mapped length in bits of the first n entries.
  function automatic logic [9:0] mapBits(input logic [7:0][31:0] ent, input logic [3:0] n);
    mapBits = '0;
    for (int i = 0; i < 8; i++) begin
      if (i < n) begin
        mapBits = mapBits + 10'(ent[i][`CNS_LEN_HI:`CNS_LEN_LO]);
      end
    end
  endfunction

  // State byte of a heartbeat; bit 7 always stays clear.
  function automatic logic [7:0] stateCode(input cns_pkg::cns_nmt_e st);
    unique case (st)
      cns_pkg::CNS_NMT_INIT:    stateCode = `CNS_ST_BOOT;
      cns_pkg::CNS_NMT_PREOP:   stateCode = `CNS_ST_PREOP;
      cns_pkg::CNS_NMT_OPER:    stateCode = `CNS_ST_OPER;
      cns_pkg::CNS_NMT_STOPPED: stateCode = `CNS_ST_STOPPED;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Object access and communication settings
  // ----------------------------------------------------------------
  cns_pkg::cns_comm_s   cfg_r, cfg_nxt, ds_r, ds_nxt;
  cns_pkg::cns_od_rsp_s rsp_r, rsp_nxt;
  logic                 dsValid_r, dsValid_nxt;
  logic                 kick;
  logic                 consRestart;
  logic                 ok;
  logic [31:0]          rdat;
  logic [2:0]           slot;
  logic [2:0]           entIdx;
  logic                 isMap;
  logic                 isCom;

  // Decode one dictionary access; a refused write leaves every setting untouched.
  always_comb begin
    cfg_nxt     = cfg_r;
    rsp_nxt     = '0;
    kick        = 1'b0;
    consRestart = 1'b0;
    ok          = 1'b0;
    rdat        = '0;
    slot        = {odReq.index[11], odReq.index[1:0]};
    entIdx      = 3'(odReq.sub - 8'h01);
    isMap       = inQuad(odReq.index, `CNS_IDX_RXMAP) | inQuad(odReq.index, `CNS_IDX_TXMAP);
    isCom       = inQuad(odReq.index, `CNS_IDX_RXCOM) | inQuad(odReq.index, `CNS_IDX_TXCOM);
    if (odReq.wr | odReq.rd) begin
      rsp_nxt.done = 1'b1;
      if (odReq.index == `CNS_IDX_CONS && odReq.sub == `CNS_SUB_COUNT) begin
        ok   = odReq.rd;
        rdat = `CNS_CONS_ENTRIES;
      end else if (odReq.index == `CNS_IDX_CONS && odReq.sub == `CNS_SUB_CONS) begin
        ok   = odReq.rd | (odReq.wdata[`CNS_RSV_HI:`CNS_RSV_LO] == 8'h00);
        rdat = cfg_r.consSet;
        if (odReq.wr && ok) begin
          cfg_nxt.consSet = odReq.wdata;
          consRestart     = 1'b1;
        end
      end else if (odReq.index == `CNS_IDX_PROD && odReq.sub == `CNS_SUB_COUNT) begin
        ok   = odReq.rd | (odReq.wdata[31:16] == 16'h0000);
        rdat = {16'h0000, cfg_r.prodTime};
        if (odReq.wr && ok) begin
          cfg_nxt.prodTime = odReq.wdata[15:0];
          kick             = (odReq.wdata[15:0] != 16'h0000);
        end
      end else if (isCom && odReq.sub == `CNS_SUB_TTYPE) begin
        ok   = odReq.rd | (odReq.wdata[31:8] == 24'h000000);
        rdat = {24'h000000, cfg_r.transType[slot]};
        if (odReq.wr && ok) begin
          cfg_nxt.transType[slot] = odReq.wdata[7:0];
        end
      end else if (isMap && odReq.sub == `CNS_SUB_COUNT) begin
        // Count and payload are checked together, but the 10-bit bit total wraps, so a payload above 1023 bits can still go live.
        ok   = odReq.rd | ((odReq.wdata[31:4] == 28'h0000000)
               && (odReq.wdata[3:0] <= `CNS_MAP_MAX_OBJ)
               && (mapBits(cfg_r.mapEntry[slot], odReq.wdata[3:0]) <= `CNS_MAP_MAX_BITS));
        rdat = {28'h0000000, cfg_r.mapCount[slot]};
        if (odReq.wr && ok) begin
          cfg_nxt.mapCount[slot] = odReq.wdata[3:0];
        end
      end else if (isMap && odReq.sub != `CNS_SUB_COUNT && odReq.sub <= 8'h08) begin
        // Entries change only while the mapping is switched off.
        ok   = odReq.rd | (cfg_r.mapCount[slot] == 4'h0);
        rdat = cfg_r.mapEntry[slot][entIdx];
        if (odReq.wr && ok) begin
          cfg_nxt.mapEntry[slot][entIdx] = odReq.wdata;
        end
      end else if (odReq.index == `CNS_IDX_WSRC && odReq.sub == `CNS_SUB_COUNT) begin
        ok   = odReq.rd | (odReq.wdata[31:1] == 31'h00000000);
        rdat = {31'h00000000, cfg_r.watchSrc};
        if (odReq.wr && ok) begin
          cfg_nxt.watchSrc = odReq.wdata[0];
        end
      end else if (odReq.index == `CNS_IDX_WLIM && odReq.sub == `CNS_SUB_COUNT) begin
        ok   = odReq.rd | (odReq.wdata[31:16] == 16'h0000);
        rdat = {16'h0000, cfg_r.watchLimit};
        if (odReq.wr && ok) begin
          cfg_nxt.watchLimit = odReq.wdata[15:0];
        end
      end
      rsp_nxt.abort = ~ok;
      rsp_nxt.rdata = (ok && odReq.rd) ? rdat : 32'h00000000;
    end
    // A restore replaces the whole set and outranks a write in the same cycle.
    if (restoreCmd && dsValid_r) begin
      cfg_nxt     = ds_r;
      kick        = (ds_r.prodTime != 16'h0000);
      consRestart = 1'b1;
    end
  end

  // Snapshot of the settings for later restore.
  always_comb begin
    ds_nxt      = ds_r;
    dsValid_nxt = dsValid_r;
    if (storeCmd) begin
      ds_nxt      = cfg_r;
      dsValid_nxt = 1'b1;
    end
  end

  // Reset leaves every mapping empty, so no process data can flow yet.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cfg_r           <= '0;
      cfg_r.transType <= {8{`CNS_TTYPE_RST}};
      ds_r            <= '0;
      dsValid_r       <= 1'b0;
      rsp_r           <= '0;
    end else begin
      cfg_r     <= cfg_nxt;
      ds_r      <= ds_nxt;
      dsValid_r <= dsValid_nxt;
      rsp_r     <= rsp_nxt;
    end
  end

  assign odRsp        = rsp_r;
  assign datasetValid = dsValid_r;

  // A process-data object is live only with a nonzero mapping count.
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      pdoActive[p] = (cfg_r.mapCount[p] != 4'h0);
    end
  end

  // ----------------------------------------------------------------
  // Heartbeat producer
  // ----------------------------------------------------------------
  cns_pkg::cns_nmt_e nmtPrev_r;
  logic [15:0]       hbCnt_r, hbCnt_nxt;
  logic              hbTxValid_r, hbTxValid_nxt;
  logic [7:0]        hbTxState_r, hbTxState_nxt;
  logic              send;
  logic              bootEdge;

  // Runs apart from the consumer; only the settings are shared.
  always_comb begin
    send          = 1'b0;
    hbCnt_nxt     = hbCnt_r;
    hbTxState_nxt = hbTxState_r;
    bootEdge      = (nmtPrev_r == cns_pkg::CNS_NMT_INIT) && (nmtState == cns_pkg::CNS_NMT_PREOP);
    if (kick && nmtState != cns_pkg::CNS_NMT_INIT) begin
      send          = 1'b1;
      hbCnt_nxt     = 16'h0000;
      hbTxState_nxt = stateCode(nmtState);
    end else if (cfg_r.prodTime == 16'h0000) begin
      hbCnt_nxt = 16'h0000;
    end else if (bootEdge) begin
      send          = 1'b1;
      hbCnt_nxt     = 16'h0000;
      hbTxState_nxt = `CNS_ST_BOOT;
    end else if (nmtState != cns_pkg::CNS_NMT_INIT && msTick) begin
      if (hbCnt_r + 16'h0001 >= cfg_r.prodTime) begin
        send          = 1'b1;
        hbCnt_nxt     = 16'h0000;
        hbTxState_nxt = stateCode(nmtState);
      end else begin
        hbCnt_nxt = hbCnt_r + 16'h0001;
      end
    end
    // A new heartbeat wins over the acceptance of the previous one.
    hbTxValid_nxt = send | (hbTxValid_r & ~hbTxReady);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      nmtPrev_r   <= cns_pkg::CNS_NMT_INIT;
      hbCnt_r     <= '0;
      hbTxValid_r <= 1'b0;
      hbTxState_r <= '0;
    end else begin
      nmtPrev_r   <= nmtState;
      hbCnt_r     <= hbCnt_nxt;
      hbTxValid_r <= hbTxValid_nxt;
      hbTxState_r <= hbTxState_nxt;
    end
  end

  assign hbTxValid = hbTxValid_r;
  assign hbTxState = hbTxState_r;

  // ----------------------------------------------------------------
  // Heartbeat consumer
  // ----------------------------------------------------------------
  cns_pkg::cns_cons_e consSt_r, consSt_nxt;
  logic [15:0]        consCnt_r, consCnt_nxt;
  logic [6:0]         consPeer_r, consPeer_nxt;
  logic               hbEvent_r, hbEvent_nxt;
  logic [15:0]        consTime;
  logic               rxMatch;

  // Supervision arms on the first heartbeat of the watched node only.
  always_comb begin
    consSt_nxt   = consSt_r;
    consCnt_nxt  = consCnt_r;
    consPeer_nxt = consPeer_r;
    hbEvent_nxt  = 1'b0;
    consTime     = cfg_r.consSet[`CNS_TIME_HI:`CNS_TIME_LO];
    rxMatch      = hbRxValid && (hbRxNode == cfg_r.consSet[`CNS_NODE_HI:`CNS_NODE_LO]);
    if (consRestart || consTime == 16'h0000) begin
      consSt_nxt  = cns_pkg::CNS_CONS_IDLE;
      consCnt_nxt = 16'h0000;
    end else if (rxMatch) begin
      consSt_nxt   = cns_pkg::CNS_CONS_RUN;
      consCnt_nxt  = 16'h0000;
      consPeer_nxt = hbRxState[6:0];
    end else if (consSt_r == cns_pkg::CNS_CONS_RUN && msTick) begin
      if (consCnt_r + 16'h0001 >= consTime) begin
        hbEvent_nxt = 1'b1;
        consSt_nxt  = cns_pkg::CNS_CONS_LOST;
      end else begin
        consCnt_nxt = consCnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      consSt_r   <= cns_pkg::CNS_CONS_IDLE;
      consCnt_r  <= '0;
      consPeer_r <= '0;
      hbEvent_r  <= 1'b0;
    end else begin
      consSt_r   <= consSt_nxt;
      consCnt_r  <= consCnt_nxt;
      consPeer_r <= consPeer_nxt;
      hbEvent_r  <= hbEvent_nxt;
    end
  end

  assign hbEvent       = hbEvent_r;
  assign consKnown     = (consSt_r != cns_pkg::CNS_CONS_IDLE);
  assign consPeerState = consPeer_r;

  // ----------------------------------------------------------------
  // Telegram failure watch
  // ----------------------------------------------------------------
  logic [15:0] wCnt_r, wCnt_nxt;
  logic        failed_r, failed_nxt;
  logic        failEvt_r, failEvt_nxt;
  logic        errV_r, errV_nxt;
  logic        seen;

  // A telegram in the same cycle as a tick restarts the count, so it is never missed.
  always_comb begin
    wCnt_nxt    = wCnt_r;
    failed_nxt  = failed_r;
    failEvt_nxt = 1'b0;
    seen        = cfg_r.watchSrc ? rxPdoRx : syncRx;
    if (cfg_r.watchLimit == 16'h0000) begin
      wCnt_nxt   = 16'h0000;
      failed_nxt = 1'b0;
    end else if (seen) begin
      wCnt_nxt   = 16'h0000;
      failed_nxt = 1'b0;
    end else if (msTick && !failed_r) begin
      if (wCnt_r + 16'h0001 >= cfg_r.watchLimit) begin
        failed_nxt  = 1'b1;
        failEvt_nxt = 1'b1;
      end else begin
        wCnt_nxt = wCnt_r + 16'h0001;
      end
    end
    // The error message stays offered until the error path takes it.
    errV_nxt = failEvt_nxt | (errV_r & ~errMsgReady);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wCnt_r    <= '0;
      failed_r  <= 1'b0;
      failEvt_r <= 1'b0;
      errV_r    <= 1'b0;
    end else begin
      wCnt_r    <= wCnt_nxt;
      failed_r  <= failed_nxt;
      failEvt_r <= failEvt_nxt;
      errV_r    <= errV_nxt;
    end
  end

  assign tlgFailEvt  = failEvt_r;
  assign tlgFailed   = failed_r;
  assign errMsgValid = errV_r;

endmodule // cns_node_supervision

// ==== bench/cns_node_supervision_chk.sv ====
// Port-level assertions for the node supervision block.
`timescale 1ns/1ps
`include "cns_defines.svh"
module cns_node_supervision_chk (
  input wire logic            clk_sys,
  input wire logic            reset,
  input cns_pkg::cns_od_req_s odReq,
  input cns_pkg::cns_od_rsp_s odRsp,
  input cns_pkg::cns_nmt_e    nmtState,
  input wire logic            hbTxValid,
  input wire logic            hbTxReady,
  input wire logic [7:0]      hbTxState,
  input wire logic            hbEvent,
  input wire logic            consKnown,
  input wire logic            tlgFailEvt,
  input wire logic            tlgFailed,
  input wire logic            errMsgValid,
  input wire logic            errMsgReady
);
  // ----------------------------------------
  // Clocking, one domain only
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // ----------------------------------------
  // Dictionary and heartbeat producer
  // ----------------------------------------
  // Each request gets its answer at the next edge, never later.
  AST_DONE_NEXT: assert property ((odReq.wr || odReq.rd) |=> odRsp.done)
    else $error("dictionary request not answered next cycle");
  AST_STATE_CODE: assert property (hbTxValid |-> hbTxState inside {8'h00, 8'h04, 8'h05, 8'h7F})
    else $error("heartbeat state byte outside the legal codes");
  AST_HB_HOLD: assert property (hbTxValid && !hbTxReady |=> hbTxValid)
    else $error("heartbeat dropped before the master took it");
  AST_WR_START: assert property (odReq.wr && odReq.index == `CNS_IDX_PROD && odReq.sub == 8'h00
    && odReq.wdata != 32'h0 && odReq.wdata <= 32'h0000FFFF
    && nmtState != cns_pkg::CNS_NMT_INIT |=> hbTxValid)
    else $error("nonzero producer period did not start a heartbeat");
  // A fresh heartbeat in a settled operational state carries code 05h.
  AST_OPER_CODE: assert property ($rose(hbTxValid) && $past(nmtState) == cns_pkg::CNS_NMT_OPER
    && nmtState == cns_pkg::CNS_NMT_OPER |-> hbTxState == 8'h05)
    else $error("heartbeat in operational state carries wrong code");
  AST_BOOT_CODE: assert property ($rose(hbTxValid) && $past(nmtState) == cns_pkg::CNS_NMT_PREOP
    && $past(nmtState, 2) == cns_pkg::CNS_NMT_INIT |-> hbTxState == 8'h00)
    else $error("first heartbeat after init is not the boot-up code");

  // ----------------------------------------
  // Consumer and telegram watch
  // ----------------------------------------
  AST_IDLE_NO_EVT: assert property (!consKnown |-> !hbEvent)
    else $error("heartbeat event while the peer is still unknown");
  AST_EVT_PULSE: assert property (hbEvent |=> !hbEvent)
    else $error("heartbeat event longer than one cycle");
  AST_FAIL_ERR: assert property (tlgFailEvt |-> tlgFailed ##[0:1] errMsgValid)
    else $error("telegram failure without an error message");
  AST_ERR_HOLD: assert property (errMsgValid && !errMsgReady |=> errMsgValid)
    else $error("error message dropped before it was taken");
endmodule // cns_node_supervision_chk

bind cns_node_supervision cns_node_supervision_chk u_chk (.clk_sys, .reset, .odReq, .odRsp,
  .nmtState, .hbTxValid, .hbTxReady, .hbTxState, .hbEvent, .consKnown, .tlgFailEvt,
  .tlgFailed, .errMsgValid, .errMsgReady);

// ==== bench/cns_master_model.sv ====
// Behavioural network master that takes heartbeats and error messages.
`timescale 1ns/1ps
module cns_master_model (
  input  wire logic       clk_sys,
  input  wire logic       stall,
  input  wire logic       hbTxValid,
  input  wire logic [7:0] hbTxState,
  input  wire logic       errMsgValid,
  output logic            hbTxReady,
  output logic            errMsgReady,
  output int              hbSeen,
  output logic [7:0]      hbLast,
  output int              errSeen
);
  // ----------------------------------------
  // Acceptance
  // ----------------------------------------
  // Stall holds both answers off, so the block must keep its offers standing.
  assign hbTxReady   = !stall;
  assign errMsgReady = !stall;

  // Tally what was taken; this master only consumes heartbeats and error messages and never polls by guarding.
  initial begin
    hbSeen  = 0;
    errSeen = 0;
    hbLast  = 8'hFF;
  end
  always @(posedge clk_sys) begin
    if (hbTxValid && hbTxReady) begin
      hbSeen <= hbSeen + 1;
      hbLast <= hbTxState;
    end
    if (errMsgValid && errMsgReady) errSeen <= errSeen + 1;
  end
endmodule // cns_master_model

// ==== bench/testbench.sv ====
// Self-checking testbench for the node supervision block.
`timescale 1ns/1ps
`include "cns_defines.svh"
module testbench;
  logic                 clk_sys, reset, msTick, storeCmd, restoreCmd, datasetValid;
  logic                 hbTxValid, hbTxReady, hbRxValid, hbEvent, consKnown, syncRx;
  logic                 rxPdoRx, tlgFailEvt, tlgFailed, errMsgValid, errMsgReady, stall;
  logic [7:0]           hbTxState, hbRxNode, hbRxState, pdoActive, hbLast;
  logic [6:0]           consPeerState;
  cns_pkg::cns_od_req_s odReq;
  cns_pkg::cns_od_rsp_s odRsp;
  cns_pkg::cns_nmt_e    nmtState;
  int                   nFail, samplesChecked, hbSeen, errSeen, nEvt, nTlg, h;

  cns_node_supervision dut (.clk_sys, .reset, .msTick, .odReq, .odRsp, .nmtState, .storeCmd,
    .restoreCmd, .datasetValid, .hbTxValid, .hbTxReady, .hbTxState, .hbRxValid, .hbRxNode,
    .hbRxState, .hbEvent, .consKnown, .consPeerState, .syncRx, .rxPdoRx, .tlgFailEvt,
    .tlgFailed, .errMsgValid, .errMsgReady, .pdoActive);
  cns_master_model peer (.clk_sys, .stall, .hbTxValid, .hbTxState, .errMsgValid, .hbTxReady,
    .errMsgReady, .hbSeen, .hbLast, .errSeen);

  // ----------------------------------------
  // Clock, monitors and tasks
  // ----------------------------------------
  // Free-running 50 MHz clock.
  always #10 clk_sys = ~clk_sys;
  // Event pulses are counted so that a missing or extra pulse shows up.
  always @(posedge clk_sys) begin
    if (hbEvent) nEvt <= nEvt + 1;
    if (tlgFailEvt) nTlg <= nTlg + 1;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nFail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One dictionary access; the answer is looked at in the single cycle it stands.
  task automatic od(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                    input logic [31:0] wd, input logic ab, input logic [31:0] rd);
    @(posedge clk_sys) #1 odReq = '{wr, !wr, idx, sub, wd};
    @(posedge clk_sys) #1 odReq = '0;
    check($sformatf("done %h/%h", idx, sub), odRsp.done, 1'b1);
    check($sformatf("abort %h/%h", idx, sub), odRsp.abort, ab);
    check($sformatf("rdata %h/%h", idx, sub), odRsp.rdata, wr ? 32'h0 : rd);
  endtask

  task automatic pulse(ref logic s);
    @(posedge clk_sys) #1 s = 1'b1;
    @(posedge clk_sys) #1 s = 1'b0;
  endtask

  task automatic ticks(input int n);
    repeat (n) pulse(msTick);
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic hbrx(input logic [7:0] node, input logic [7:0] st);
    @(posedge clk_sys) #1 {hbRxNode, hbRxState, hbRxValid} = {node, st, 1'b1};
    @(posedge clk_sys) #1 hbRxValid = 1'b0;
    @(posedge clk_sys) #1;
  endtask

  task automatic printVerdict;
    $display("comparisons %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // A hang is cut short well beyond the expected run of about 250 cycles.
  initial begin
    repeat (20000) @(posedge clk_sys);
    nFail++;
    printVerdict;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {clk_sys, msTick, storeCmd, restoreCmd, hbRxValid, syncRx, rxPdoRx, stall} = '0;
    {hbRxNode, hbRxState, nFail, samplesChecked, nEvt, nTlg} = '0;
    odReq = '0;
    nmtState = cns_pkg::CNS_NMT_INIT;
    reset = 1'b1;
    repeat (20) @(posedge clk_sys);
    #1 reset = 1'b0;
    // Mappings start empty at their fixed indexes; the consumer has one entry.
    for (int i = 0; i < 4; i++) begin
      od(0, 16'h1600 + 16'(i), 0, 0, 0, 0);
      od(0, 16'h1A00 + 16'(i), 0, 0, 0, 0);
    end
    check("pdoActive", pdoActive, 8'h00);
    od(0, `CNS_IDX_CONS, 0, 0, 0, 1);
    od(1, `CNS_IDX_CONS, 0, 5, 1, 0);
    od(0, `CNS_IDX_CONS, 2, 0, 1, 0);
    // Eight one-byte pad entries fill the limit exactly; nine objects or 72 bits are refused.
    od(1, 16'h1600, 0, 9, 1, 0);
    for (int i = 1; i <= 8; i++) od(1, 16'h1600, 8'(i), 32'h2807_0008, 0, 0);
    od(1, 16'h1600, 0, 8, 0, 0);
    od(1, 16'h1600, 1, 32'h2807_0008, 1, 0);
    od(1, 16'h1A00, 1, 32'h3000_0120, 0, 0);
    od(1, 16'h1A00, 2, 32'h3001_0120, 0, 0);
    od(1, 16'h1A00, 3, 32'h2807_0008, 0, 0);
    od(1, 16'h1A00, 0, 3, 1, 0);
    od(1, 16'h1A00, 0, 2, 0, 0);
    check("pdoActive", pdoActive, 8'h11);
    // Store, disturb, then restore the whole set in one step.
    od(1, 16'h1800, 2, 32'hFE, 0, 0);
    od(1, 16'h1800, 2, 32'h100, 1, 0);
    pulse(storeCmd);
    check("datasetValid", datasetValid, 1'b1);
    od(1, 16'h1600, 0, 0, 0, 0);
    od(1, 16'h1800, 2, 32'h01, 0, 0);
    check("pdoActive", pdoActive, 8'h10);
    pulse(restoreCmd);
    od(0, 16'h1600, 0, 0, 0, 8);
    od(0, 16'h1600, 8, 0, 0, 32'h2807_0008);
    od(0, 16'h1800, 2, 0, 0, 32'hFE);
    // Period set during init: nothing until pre-operational, then boot-up, then 7Fh.
    od(1, `CNS_IDX_PROD, 0, 2, 0, 0);
    check("hbSeen", hbSeen, 0);
    nmtState = cns_pkg::CNS_NMT_PREOP;
    repeat (3) @(posedge clk_sys);
    check("hbSeen", hbSeen, 1);
    check("hbLast", hbLast, 8'h00);
    ticks(2);
    check("hbSeen", hbSeen, 2);
    check("hbLast", hbLast, 8'h7F);
    // A new period starts at once, then one heartbeat every three ticks.
    nmtState = cns_pkg::CNS_NMT_OPER;
    od(1, `CNS_IDX_PROD, 0, 3, 0, 0);
    // The heartbeat is offered at the edge that takes the write; the master takes it one edge later.
    @(posedge clk_sys) #1;
    check("hbLast", hbLast, 8'h05);
    ticks(6);
    check("hbSeen", hbSeen, 5);
    od(1, `CNS_IDX_PROD, 0, 32'h1_0000, 1, 0);
    // A stalled master sees the stopped code standing until it accepts.
    nmtState = cns_pkg::CNS_NMT_STOPPED;
    stall = 1'b1;
    od(1, `CNS_IDX_PROD, 0, 1, 0, 0);
    repeat (4) @(posedge clk_sys);
    // Step off the edge so that the release of the stall does not race the sampling edge.
    #1;
    check("hbTxValid", hbTxValid, 1'b1);
    check("hbTxState", hbTxState, 8'h04);
    stall = 1'b0;
    od(1, `CNS_IDX_PROD, 0, 0, 0, 0);
    h = hbSeen;
    ticks(4);
    check("hbSeen", hbSeen, h);
    // Consumer stays idle until its node speaks, then times out on the fifth silent tick.
    nmtState = cns_pkg::CNS_NMT_OPER;
    od(1, `CNS_IDX_PROD, 0, 2, 0, 0);
    h = hbSeen;
    od(1, `CNS_IDX_CONS, 1, 32'h0122_0005, 1, 0);
    od(1, `CNS_IDX_CONS, 1, 32'h0022_0005, 0, 0);
    od(0, `CNS_IDX_CONS, 1, 0, 0, 32'h0022_0005);
    ticks(8);
    hbrx(8'h21, 8'h05);
    check("consKnown", consKnown, 1'b0);
    hbrx(8'h22, 8'h7F);
    check("consKnown", consKnown, 1'b1);
    check("consPeerState", consPeerState, 7'h7F);
    ticks(4);
    check("nEvt", nEvt, 0);
    ticks(1);
    check("nEvt", nEvt, 1);
    check("hbSeen", hbSeen, h + 7);
    // Watch on SYNC with a three-tick limit, then on received process data.
    od(1, `CNS_IDX_WSRC, 0, 2, 1, 0);
    od(1, `CNS_IDX_WLIM, 0, 3, 0, 0);
    pulse(syncRx);
    ticks(2);
    pulse(syncRx);
    ticks(2);
    check("nTlg", nTlg, 0);
    ticks(1);
    check("nTlg", nTlg, 1);
    check("tlgFailed", tlgFailed, 1'b1);
    check("errSeen", errSeen, 1);
    od(1, `CNS_IDX_WSRC, 0, 1, 0, 0);
    pulse(rxPdoRx);
    check("tlgFailed", tlgFailed, 1'b0);
    stall = 1'b1;
    ticks(2);
    pulse(syncRx);
    ticks(1);
    check("nTlg", nTlg, 2);
    check("errMsgValid", errMsgValid, 1'b1);
    stall = 1'b0;
    repeat (2) @(posedge clk_sys);
    check("errSeen", errSeen, 2);
    od(1, `CNS_IDX_WLIM, 0, 0, 0, 0);
    ticks(5);
    check("nTlg", nTlg, 2);
    printVerdict;
  end
endmodule // testbench
